// File: synth_cfg_defs.vh
// Register offsets, field positions and reset values of the loop config bank
`ifndef SYNTH_CFG_DEFS_VH
`define SYNTH_CFG_DEFS_VH

`define ADDR_W 8
`define DATA_W 8

`define OFF_PWD_INT 8'h90
`define OFF_PWD_FRAC 8'h91
`define OFF_PUMP_CFG 8'h9A
`define OFF_LOCK_CFG 8'h9B
`define OFF_OSC1_LOCK 8'h9C
`define OFF_OSC2_LOCK 8'h9D
`define OFF_BYP_REF 8'h9E
`define OFF_RSVD 8'h9F

// Index of the first register in the PLL control group
`define PLL_BASE 8'h9A
`define PLL_REGS 6

// Field positions in the pump / filter register
`define PUMP_MSB 7
`define PUMP_LSB 5
`define RSER_MSB 4
`define RSER_LSB 3
`define CPAR_MSB 2
`define CPAR_LSB 1
`define POLE_BIT 0
// Lock detect register
`define LACC_BIT 1
`define LMAN_BIT 0
// Manual lock registers
`define OSC_SEL_BIT 5
`define LCTL_MSB 4
`define LCTL_LSB 0
// Bypass / reference / prescaler register
`define BYP_BIT 4
`define REFOE_BIT 2
`define PRE_MSB 1
`define PRE_LSB 0

// Divider power-down bit positions
`define PWD_INT_MSB 1
`define PWD_FRAC_MSB 7

// Writable-bit masks; reserved positions are never stored
`define MASK_PWD_INT 8'h03
`define MASK_PWD_FRAC 8'hFF
`define MASK_PUMP 8'hFF
`define MASK_LOCK 8'h03
`define MASK_OSC1 8'h3F
`define MASK_OSC2 8'h1F
`define MASK_BYP 8'h17

// Reset values
`define RST_PWD 8'h00
`define RST_PUMP 8'h8B
`define RST_LOCK 8'h02
`define RST_OSC1 8'h2B
`define RST_OSC2 8'h00
`define RST_BYP 8'h03

// Prescaler codes
`define PRE_DIV1 2'h0
`define PRE_DIV2 2'h1
`define PRE_DIV4 2'h2
`define PRE_MUL2 2'h3

`endif

// File: cfg_reg_bit.v
// One configuration register with reset value and writable mask
`timescale 1ns/1ps
module cfg_reg_bit #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}},
    parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_we,
    input wire [WIDTH-1:0] i_wdata,
    output wire [WIDTH-1:0] o_q
);
    reg [WIDTH-1:0] val_q;
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            val_q <= RST_VAL;
        end else if (i_we) begin
            val_q <= i_wdata & MASK;
        end
    end
    assign o_q = val_q;
endmodule // cfg_reg_bit

// File: ref_prescaler.v
// Reference pre-scaler strobe: divide by 1, 2, 4 or double
`timescale 1ns/1ps
`include "synth_cfg_defs.vh"
module ref_prescaler (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [1:0] i_mode,
    input wire i_ref_edge,
    output reg o_pll_edge
);
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg pulse_d;
    // Doubling yields a strobe on the edge and its follower cycle
    reg dbl_q;
    always @* begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        case (i_mode)
            `PRE_DIV1: pulse_d = i_ref_edge;
            `PRE_DIV2: begin
                if (i_ref_edge) begin
                    cnt_d = {1'b0, ~cnt_q[0]};
                    pulse_d = cnt_q[0];
                end
            end
            `PRE_DIV4: begin
                if (i_ref_edge) begin
                    cnt_d = cnt_q + 2'h1;
                    pulse_d = (cnt_q == 2'h3);
                end
            end
            `PRE_MUL2: pulse_d = i_ref_edge | dbl_q;
            default: pulse_d = 1'b0;
        endcase
    end
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_q <= 2'h0;
            dbl_q <= 1'b0;
            o_pll_edge <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dbl_q <= (i_mode == `PRE_MUL2) & i_ref_edge;
            o_pll_edge <= pulse_d; // RULE_14
        end
    end
endmodule // ref_prescaler

// File: synth_loop_cfg.v
// Divider power-down and PLL loop configuration register bank
//
// Contract
// (RULE_01) Divider power-down bits: set powers down, reset 0
// (RULE_02) Reserved bits written zero; reads undefined
// (RULE_03) Pump current code 110uA steps, reset 100b
// (RULE_04) Series resistor code, reset 01b
// (RULE_05) Parallel capacitor code, reset 01b
// (RULE_06) Second pole select, reset 1b
// (RULE_07) Lock accuracy bit: clear 1ppm, set 16ppm
// (RULE_08) Lock override: set selects manual mode, reset 0
// (RULE_09) Manual oscillator choice: set first VCO, reset 1
// (RULE_10) Two 5-bit manual lock values with defaults
// (RULE_11) Bypass bit routes reference to Q0-Q3
// (RULE_12) Reference output high impedance when disabled
// (RULE_13) Enabled reference output follows selected input
// (RULE_14) Pre-scaler divides 1,2,4 or multiplies 2
// (RULE_15) All fields take defaults at reset
`timescale 1ns/1ps
`include "synth_cfg_defs.vh"
module synth_loop_cfg #(
    parameter N_INT_DIV = 2,
    parameter N_FRAC_DIV = 8
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    // Host register port, one access per strobe
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [`DATA_W-1:0] i_wdata,
    output reg [`DATA_W-1:0] o_rdata,
    output reg o_rvalid,
    // Pins seen by the config path
    input wire i_bypass_pin,
    input wire i_clk_sel,
    input wire i_xtal_ref,
    input wire i_clkin_ref,
    input wire i_ref_edge,
    // Decoded controls to the analog loop and dividers
    output reg [N_INT_DIV-1:0] o_output_divider_powerdown_int,
    output reg [N_FRAC_DIV-1:0] o_output_divider_powerdown_frac,
    output reg [2:0] o_pump_current_sel,
    output reg [3:0] o_pump_current_steps,
    output reg [1:0] o_loop_series_resistor_sel,
    output reg [1:0] o_loop_parallel_cap_sel,
    output reg o_second_pole_sel,
    output reg o_lock_count_accuracy,
    output reg o_lock_manual_override,
    output reg o_manual_oscillator_choice,
    output reg [4:0] o_active_manual_lock_ctl,
    output reg [4:0] o_osc1_manual_lock_ctl,
    output reg [4:0] o_osc2_manual_lock_ctl,
    output reg o_synth_bypass,
    output reg [1:0] o_prescale_mode,
    output reg o_pll_ref_edge,
    output reg o_ref_out,
    output reg o_ref_out_oe
);
    wire [7:0] pwd_int;
    wire [7:0] pwd_frac;
    wire [7:0] pump;
    wire [7:0] lockc;
    wire [7:0] osc1;
    wire [7:0] osc2;
    wire [7:0] bypr;
    wire [7:0] rst_vals [0:6];
    wire [7:0] masks [0:6];
    wire [7:0] offs [0:6];
    wire [7:0] q_all [0:6];
    wire pre_edge;

    assign offs[0] = `OFF_PWD_INT;
    assign offs[1] = `OFF_PWD_FRAC;
    assign offs[2] = `OFF_PUMP_CFG;
    assign offs[3] = `OFF_LOCK_CFG;
    assign offs[4] = `OFF_OSC1_LOCK;
    assign offs[5] = `OFF_OSC2_LOCK;
    assign offs[6] = `OFF_BYP_REF;

    // Masks drop reserved bits so they read back zero
    cfg_reg_bit #(.RST_VAL(`RST_PWD), .MASK(`MASK_PWD_INT)) u_pwd_int (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_PWD_INT),
        .i_wdata(i_wdata), .o_q(pwd_int)); // RULE_01
    cfg_reg_bit #(.RST_VAL(`RST_PWD), .MASK(`MASK_PWD_FRAC)) u_pwd_frac (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_PWD_FRAC),
        .i_wdata(i_wdata), .o_q(pwd_frac)); // RULE_01
    cfg_reg_bit #(.RST_VAL(`RST_PUMP), .MASK(`MASK_PUMP)) u_pump (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_PUMP_CFG),
        .i_wdata(i_wdata), .o_q(pump)); // RULE_15
    cfg_reg_bit #(.RST_VAL(`RST_LOCK), .MASK(`MASK_LOCK)) u_lock (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_LOCK_CFG),
        .i_wdata(i_wdata), .o_q(lockc)); // RULE_15
    cfg_reg_bit #(.RST_VAL(`RST_OSC1), .MASK(`MASK_OSC1)) u_osc1 (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_OSC1_LOCK),
        .i_wdata(i_wdata), .o_q(osc1)); // RULE_10
    cfg_reg_bit #(.RST_VAL(`RST_OSC2), .MASK(`MASK_OSC2)) u_osc2 (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_OSC2_LOCK),
        .i_wdata(i_wdata), .o_q(osc2)); // RULE_10
    cfg_reg_bit #(.RST_VAL(`RST_BYP), .MASK(`MASK_BYP)) u_byp (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_we(i_wr_en && i_addr == `OFF_BYP_REF),
        .i_wdata(i_wdata), .o_q(bypr)); // RULE_15

    assign q_all[0] = pwd_int;
    assign q_all[1] = pwd_frac;
    assign q_all[2] = pump;
    assign q_all[3] = lockc;
    assign q_all[4] = osc1;
    assign q_all[5] = osc2;
    assign q_all[6] = bypr;

    ref_prescaler u_pre (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_mode(bypr[`PRE_MSB:`PRE_LSB]),
        .i_ref_edge(i_ref_edge),
        .o_pll_edge(pre_edge)
    );

    // Read mux; reserved and unmapped offsets read zero
    reg [7:0] rd_d;
    integer k;
    always @* begin
        rd_d = 8'h00; // RULE_02
        for (k = 0; k < 7; k = k + 1) begin
            if (i_addr == offs[k]) begin
                rd_d = q_all[k];
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rd_d;
            end
        end
    end

    // Registered decode of every control to the analog side
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_output_divider_powerdown_int <= {N_INT_DIV{1'b0}};
            o_output_divider_powerdown_frac <= {N_FRAC_DIV{1'b0}};
            o_pump_current_sel <= 3'h4;
            o_pump_current_steps <= 4'h5;
            o_loop_series_resistor_sel <= 2'h1;
            o_loop_parallel_cap_sel <= 2'h1;
            o_second_pole_sel <= 1'b1;
            o_lock_count_accuracy <= 1'b1;
            o_lock_manual_override <= 1'b0;
            o_manual_oscillator_choice <= 1'b1;
            o_active_manual_lock_ctl <= 5'h0B;
            o_osc1_manual_lock_ctl <= 5'h0B;
            o_osc2_manual_lock_ctl <= 5'h00;
            o_synth_bypass <= 1'b0;
            o_prescale_mode <= 2'h3;
            o_pll_ref_edge <= 1'b0;
            o_ref_out <= 1'b0;
            o_ref_out_oe <= 1'b0; // RULE_15
        end else begin
            o_output_divider_powerdown_int <=
                pwd_int[N_INT_DIV-1:0]; // RULE_01
            o_output_divider_powerdown_frac <=
                pwd_frac[N_FRAC_DIV-1:0]; // RULE_01
            o_pump_current_sel <= pump[`PUMP_MSB:`PUMP_LSB]; // RULE_03
            // Multiples of 110uA: code plus one
            o_pump_current_steps <=
                {1'b0, pump[`PUMP_MSB:`PUMP_LSB]} + 4'h1; // RULE_03
            o_loop_series_resistor_sel <=
                pump[`RSER_MSB:`RSER_LSB]; // RULE_04
            o_loop_parallel_cap_sel <= pump[`CPAR_MSB:`CPAR_LSB]; // RULE_05
            o_second_pole_sel <= pump[`POLE_BIT]; // RULE_06
            o_lock_count_accuracy <= lockc[`LACC_BIT]; // RULE_07
            o_lock_manual_override <= lockc[`LMAN_BIT]; // RULE_08
            o_manual_oscillator_choice <= osc1[`OSC_SEL_BIT]; // RULE_09
            o_osc1_manual_lock_ctl <= osc1[`LCTL_MSB:`LCTL_LSB]; // RULE_10
            o_osc2_manual_lock_ctl <= osc2[`LCTL_MSB:`LCTL_LSB]; // RULE_10
            // Set choice means first VCO
            o_active_manual_lock_ctl <= osc1[`OSC_SEL_BIT] ?
                osc1[`LCTL_MSB:`LCTL_LSB] :
                osc2[`LCTL_MSB:`LCTL_LSB]; // RULE_09
            // Register bit and pin share one function
            o_synth_bypass <= bypr[`BYP_BIT] | i_bypass_pin; // RULE_11
            o_prescale_mode <= bypr[`PRE_MSB:`PRE_LSB]; // RULE_14
            o_pll_ref_edge <= pre_edge; // RULE_14
            o_ref_out_oe <= bypr[`REFOE_BIT]; // RULE_12
            // Output held low while undriven to avoid a floating value
            o_ref_out <= bypr[`REFOE_BIT] &
                (i_clk_sel ? i_clkin_ref : i_xtal_ref); // RULE_13
        end
    end
endmodule // synth_loop_cfg

// File: synth_loop_cfg_props.sv
// Protocol and decode checks on the loop config bank ports
`timescale 1ns/1ps
module synth_loop_cfg_props (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_rd_en,
    input wire [7:0] o_rdata,
    input wire o_rvalid,
    input wire i_bypass_pin,
    input wire i_clk_sel,
    input wire i_xtal_ref,
    input wire i_clkin_ref,
    input wire i_ref_edge,
    input wire [2:0] o_pump_current_sel,
    input wire [3:0] o_pump_current_steps,
    input wire o_manual_oscillator_choice,
    input wire [4:0] o_active_manual_lock_ctl,
    input wire [4:0] o_osc1_manual_lock_ctl,
    input wire [4:0] o_osc2_manual_lock_ctl,
    input wire o_synth_bypass,
    input wire [1:0] o_prescale_mode,
    input wire o_pll_ref_edge,
    input wire o_ref_out,
    input wire o_ref_out_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_div1_edge;
        (o_prescale_mode == 2'h0 && i_ref_edge) ##2 (o_prescale_mode == 2'h0);
    endsequence
    a_read_gives_valid: assert property (i_rd_en |=> o_rvalid)
        else $error("read without valid");
    a_valid_needs_read: assert property (o_rvalid |-> $past(i_rd_en))
        else $error("valid without read");
    a_rdata_holds: assert property (!$past(i_rd_en) |-> $stable(o_rdata))
        else $error("read data moved without read");
    a_pump_step_count: assert property (
        o_pump_current_steps == {1'b0, o_pump_current_sel} + 4'h1)
        else $error("pump steps wrong");
    a_active_lock_mux: assert property (
        o_active_manual_lock_ctl == (o_manual_oscillator_choice ?
        o_osc1_manual_lock_ctl : o_osc2_manual_lock_ctl))
        else $error("active lock value wrong");
    a_ref_off_low: assert property (!o_ref_out_oe |-> !o_ref_out)
        else $error("reference out active while disabled");
    a_ref_follows_mux: assert property (
        o_ref_out_oe && $past(o_ref_out_oe) |-> o_ref_out == ($past(i_clk_sel)
        ? $past(i_clkin_ref) : $past(i_xtal_ref)))
        else $error("reference out not from selected input");
    a_bypass_pin_wins: assert property (
        i_bypass_pin |-> ##[1:2] o_synth_bypass)
        else $error("bypass pin ignored");
    a_div1_passes: assert property (s_div1_edge |-> o_pll_ref_edge)
        else $error("divide by one lost an edge");
endmodule // synth_loop_cfg_props

bind synth_loop_cfg synth_loop_cfg_props i_synth_loop_cfg_props (
    .i_clk_sys, .i_rst_n, .i_rd_en, .o_rdata, .o_rvalid, .i_bypass_pin,
    .i_clk_sel, .i_xtal_ref, .i_clkin_ref, .i_ref_edge, .o_pump_current_sel,
    .o_pump_current_steps, .o_manual_oscillator_choice,
    .o_active_manual_lock_ctl, .o_osc1_manual_lock_ctl,
    .o_osc2_manual_lock_ctl, .o_synth_bypass, .o_prescale_mode,
    .o_pll_ref_edge, .o_ref_out, .o_ref_out_oe);

// File: cfg_host.sv
// Host model driving the register port of the loop config bank
`timescale 1ns/1ps
module cfg_host (
    input wire i_clk_sys,
    input wire [7:0] i_rdata,
    input wire i_rvalid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr_en = 1'b0;
        // Released data is the complement of the written value, not the last value
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_rd_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        d = i_rdata;
        v = i_rvalid;
        o_rd_en = 1'b0;
    endtask
endmodule // cfg_host

// File: synth_loop_cfg_test.sv
// Self-checking bench for the loop config register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module synth_loop_cfg_test;
    logic i_clk_sys = 0, i_rst_n = 0, i_bypass_pin = 0, i_clk_sel = 0;
    logic i_xtal_ref = 0, i_clkin_ref = 0, i_ref_edge = 0;
    logic i_wr_en, i_rd_en, o_rvalid, o_second_pole_sel, o_synth_bypass;
    logic o_lock_count_accuracy, o_lock_manual_override, o_ref_out;
    logic o_manual_oscillator_choice, o_pll_ref_edge, o_ref_out_oe;
    logic [7:0] i_addr, i_wdata, o_rdata, rdv, o_output_divider_powerdown_frac;
    logic [1:0] o_output_divider_powerdown_int, o_prescale_mode;
    logic [1:0] o_loop_series_resistor_sel, o_loop_parallel_cap_sel;
    logic [2:0] o_pump_current_sel;
    logic [3:0] o_pump_current_steps;
    logic [4:0] o_active_manual_lock_ctl, o_osc1_manual_lock_ctl;
    logic [4:0] o_osc2_manual_lock_ctl;
    logic vld;
    int failures = 0, compares = 0, edges = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (o_pll_ref_edge) edges++;
    synth_loop_cfg i_synth_loop_cfg (.i_clk_sys, .i_rst_n, .i_wr_en, .i_rd_en,
        .i_addr, .i_wdata, .o_rdata, .o_rvalid, .i_bypass_pin, .i_clk_sel,
        .i_xtal_ref, .i_clkin_ref, .i_ref_edge, .o_output_divider_powerdown_int,
        .o_output_divider_powerdown_frac, .o_pump_current_sel,
        .o_pump_current_steps, .o_loop_series_resistor_sel,
        .o_loop_parallel_cap_sel, .o_second_pole_sel, .o_lock_count_accuracy,
        .o_lock_manual_override, .o_manual_oscillator_choice,
        .o_active_manual_lock_ctl, .o_osc1_manual_lock_ctl,
        .o_osc2_manual_lock_ctl, .o_synth_bypass, .o_prescale_mode,
        .o_pll_ref_edge, .o_ref_out, .o_ref_out_oe);
    cfg_host i_cfg_host (.i_clk_sys, .i_rdata(o_rdata), .i_rvalid(o_rvalid),
        .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
        .o_wdata(i_wdata));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_cfg_host.rd(a, rdv, vld);
        `CHK("rvalid", 1'b1, vld)
        `CHK("rdata", e, rdv)
    endtask
    task automatic complete_run;
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] ad[8] = '{8'h90, 8'h91, 8'h9A, 8'h9B, 8'h9C, 8'h9D,
                              8'h9E, 8'h9F};
        logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h8B, 8'h02, 8'h2B, 8'h00,
                              8'h03, 8'h00};
        `CHK("pd", 10'h000, {o_output_divider_powerdown_int, o_output_divider_powerdown_frac})
        `CHK("loop", 15'h455D, {o_pump_current_sel, o_pump_current_steps, o_loop_series_resistor_sel, o_loop_parallel_cap_sel, o_second_pole_sel, o_lock_count_accuracy, o_lock_manual_override, o_manual_oscillator_choice})
        `CHK("lock", 15'h2C0B, {o_osc1_manual_lock_ctl, o_osc2_manual_lock_ctl, o_active_manual_lock_ctl})
        `CHK("ref", 5'h0C, {o_synth_bypass, o_prescale_mode, o_ref_out_oe, o_ref_out})
        for (int i = 0; i < 8; i++) rchk(ad[i], rv[i]);
    endtask
    task automatic t_pump;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {c[2:0], c[1:0], c[1:0], c[0]};
            i_cfg_host.wr(8'h9A, d);
            tick(1);
            `CHK("pump", {c[2:0], 4'(c + 1), c[1:0], c[1:0], c[0]}, {o_pump_current_sel, o_pump_current_steps, o_loop_series_resistor_sel, o_loop_parallel_cap_sel, o_second_pole_sel})
            rchk(8'h9A, d);
        end
    endtask
    task automatic t_lock;
        // Large external loop cap assumed, so fine accuracy
        i_cfg_host.wr(8'h9B, 8'h01);
        i_cfg_host.wr(8'h9C, 8'h15);
        i_cfg_host.wr(8'h9D, 8'h0A);
        tick(1);
        `CHK("lock", 8'h4A, {o_lock_count_accuracy, o_lock_manual_override, o_manual_oscillator_choice, o_active_manual_lock_ctl})
        i_cfg_host.wr(8'h9C, 8'h35);
        tick(1);
        `CHK("osc1", 5'h15, o_active_manual_lock_ctl)
        rchk(8'h9C, 8'h35);
        rchk(8'h9D, 8'h0A);
    endtask
    task automatic t_divpd;
        i_cfg_host.wr(8'h90, 8'h02);
        i_cfg_host.wr(8'h91, 8'hA5);
        tick(1);
        `CHK("pd", 10'h2A5, {o_output_divider_powerdown_int, o_output_divider_powerdown_frac})
        rchk(8'h90, 8'h02);
        i_cfg_host.wr(8'h90, 8'h00);
        i_cfg_host.wr(8'h91, 8'h00);
        tick(1);
        `CHK("pd", 10'h000, {o_output_divider_powerdown_int, o_output_divider_powerdown_frac})
    endtask
    task automatic t_ref;
        i_cfg_host.wr(8'h9E, 8'h14);
        tick(1);
        `CHK("byp", 4'h9, {o_synth_bypass, o_prescale_mode, o_ref_out_oe})
        i_clk_sel = 1;
        i_clkin_ref = 1;
        tick(2);
        `CHK("clkin", 1'b1, o_ref_out)
        i_clk_sel = 0;
        tick(2);
        `CHK("xtal0", 1'b0, o_ref_out)
        i_xtal_ref = 1;
        tick(2);
        `CHK("xtal1", 1'b1, o_ref_out)
        i_cfg_host.wr(8'h9E, 8'h03);
        tick(1);
        `CHK("off", 3'h0, {o_ref_out_oe, o_ref_out, o_synth_bypass})
        i_bypass_pin = 1;
        tick(2);
        `CHK("pin", 1'b1, o_synth_bypass)
        i_bypass_pin = 0;
    endtask
    task automatic t_pre;
        for (int m = 0; m < 4; m++) begin
            i_cfg_host.wr(8'h9E, 8'(m));
            tick(3);
            edges = 0;
            repeat (8) begin
                i_ref_edge = 1;
                tick(1);
                i_ref_edge = 0;
                tick(3);
            end
            tick(4);
            `CHK("pre", m == 0 ? 8 : m == 1 ? 4 : m == 2 ? 2 : 16, edges)
        end
    endtask
    task automatic t_unmap;
        i_cfg_host.wr(8'h9F, 8'hFF);
        i_cfg_host.wr(8'h55, 8'hFF);
        rchk(8'h9F, 8'h00);
        rchk(8'h55, 8'h00);
        rchk(8'h9A, 8'hFF);
    endtask
    initial begin
        tick(5);
        i_rst_n = 1;
        t_reset;
        t_pump;
        t_lock;
        t_divpd;
        t_ref;
        t_pre;
        t_unmap;
        complete_run;
    end
    initial begin
        #100000;
        failures++;
        complete_run;
    end
endmodule // synth_loop_cfg_test
